// ### rtl/branch_decode_pkg.sv
// constants, encodings and carriers for the branch and move decoder
// assumes a 16-bit instruction word and an 8-bit status byte
package branch_decode_pkg;

   // ****************************************
   // geometry
   // ****************************************
   localparam int INSTR_W = 16;
   localparam int OFFS_W = 7;
   localparam int NREG = 32;
   localparam int REG_W = 8;
   localparam int RADDR_W = 5;
   localparam int PAIR_W = 4;

   // ****************************************
   // branch field layout: 1111 0x kkkkkkk sss
   // ****************************************
   localparam int BR_SEL_LSB = 0;
   localparam int BR_SEL_W = 3;
   localparam int BR_OFFS_LSB = 3;
   localparam int BR_POL_BIT = 10;
   localparam logic [4:0] BR_OPC = 5'h1e;
   localparam int BR_OPC_LSB = 11;

   // flag select codes
   localparam logic [2:0] SEL_C = 3'h0;
   localparam logic [2:0] SEL_N = 3'h2;
   localparam logic [2:0] SEL_V = 3'h3;
   localparam logic [2:0] SEL_S = 3'h4;
   localparam logic [2:0] SEL_H = 3'h5;
   localparam logic [2:0] SEL_T = 3'h6;

   // ****************************************
   // move field layout
   // ****************************************
   localparam logic [5:0] MOVB_OPC = 6'h0b;
   localparam int MOVB_OPC_LSB = 10;
   localparam logic [7:0] MOVP_OPC = 8'h01;
   localparam int MOVP_OPC_LSB = 8;
   localparam int DST_LSB = 4;
   localparam int SRC_LSB = 0;
   localparam int MOVB_DHI_BIT = 8;
   localparam int MOVB_SHI_BIT = 9;

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic i;
      logic t;
      logic h;
      logic s;
      logic v;
      logic n;
      logic z;
      logic c;
   } status_t;

   typedef struct packed {
      logic valid;
      logic [INSTR_W-1:0] word;
   } instr_t;

   typedef struct packed {
      logic en;
      logic [RADDR_W-1:0] addr;
      logic [REG_W-1:0] data;
   } reg_wr_t;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_TAKEN = 1'b1
   } phase_t;

endpackage

// ### rtl/conditional_branch_decode.sv
// decoder and executor for conditional relative branches and register copies
// assumes fetch supplies word and pc together; status byte is read only here
`timescale 1ns/10ps
`default_nettype none

module conditional_branch_decode #(
   parameter int PC_W = 12
) (
   input wire logic clk,
   input wire logic rstn,
   input wire branch_decode_pkg::instr_t instr,
   input wire logic [PC_W-1:0] pc,
   input wire branch_decode_pkg::status_t status,
   input wire branch_decode_pkg::reg_wr_t reg_wr,
   input wire logic [branch_decode_pkg::RADDR_W-1:0] rd_addr,
   output logic instr_ready,
   output logic retire,
   output logic pc_load,
   output logic [PC_W-1:0] pc_target,
   output logic unsupported,
   output logic [branch_decode_pkg::REG_W-1:0] rd_data
);

   // ****************************************
   // field widths
   // ****************************************
   localparam int BR_OPC_W = $bits(branch_decode_pkg::BR_OPC);
   localparam int MOVB_OPC_W = $bits(branch_decode_pkg::MOVB_OPC);
   localparam int MOVP_OPC_W = $bits(branch_decode_pkg::MOVP_OPC);
   localparam int LOW_W = branch_decode_pkg::RADDR_W - 1;

   // ****************************************
   // elaboration check
   // ****************************************
   if (PC_W < branch_decode_pkg::OFFS_W) begin : g_bad_pc_w
      $error("pc width narrower than branch offset");
   end
   if (branch_decode_pkg::NREG != 2 ** branch_decode_pkg::RADDR_W) begin : g_bad_nreg
      $error("register count must match the register address width");
   end
   if (branch_decode_pkg::PAIR_W != LOW_W) begin : g_bad_pair_w
      $error("pair index must be one bit narrower than a register address");
   end
   if (branch_decode_pkg::BR_OFFS_LSB + branch_decode_pkg::OFFS_W
       != branch_decode_pkg::BR_POL_BIT) begin : g_bad_offs
      $error("branch offset field must sit just below the polarity bit");
   end
   if (branch_decode_pkg::BR_OPC_LSB + BR_OPC_W
       != branch_decode_pkg::INSTR_W) begin : g_bad_br_opc
      $error("branch opcode must end at the word msb");
   end
   if (branch_decode_pkg::MOVB_OPC_LSB + MOVB_OPC_W
       != branch_decode_pkg::INSTR_W) begin : g_bad_movb_opc
      $error("byte copy opcode must end at the word msb");
   end
   if (branch_decode_pkg::MOVP_OPC_LSB + MOVP_OPC_W
       != branch_decode_pkg::INSTR_W) begin : g_bad_movp_opc
      $error("pair copy opcode must end at the word msb");
   end

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      branch_decode_pkg::phase_t phase;
      logic [PC_W-1:0] target;
      logic [branch_decode_pkg::NREG-1:0][branch_decode_pkg::REG_W-1:0] regs;
      logic [branch_decode_pkg::REG_W-1:0] rd_data;
      logic unsupported;
   } state_t;

   state_t state_r;
   state_t state_nxt;

   // ****************************************
   // decode
   // ****************************************
   logic [branch_decode_pkg::INSTR_W-1:0] w;
   logic accept;
   logic is_branch;
   logic is_movb;
   logic is_movp;
   logic pol_clear;
   logic [branch_decode_pkg::BR_SEL_W-1:0] sel;
   logic supported_br;
   logic flag_val;
   logic cond;
   logic taken;
   logic [branch_decode_pkg::OFFS_W-1:0] offs;
   logic [PC_W-1:0] offs_ext;
   logic [PC_W-1:0] branch_target;
   logic [branch_decode_pkg::RADDR_W-1:0] movb_dst;
   logic [branch_decode_pkg::RADDR_W-1:0] movb_src;
   logic [branch_decode_pkg::PAIR_W-1:0] pair_dst;
   logic [branch_decode_pkg::PAIR_W-1:0] pair_src;

   assign w = instr.word;
   assign instr_ready = (state_r.phase == branch_decode_pkg::ST_IDLE);
   assign accept = instr.valid && instr_ready;
   assign is_branch = (w[branch_decode_pkg::BR_OPC_LSB +: BR_OPC_W]
                       == branch_decode_pkg::BR_OPC);
   assign is_movb = (w[branch_decode_pkg::MOVB_OPC_LSB +: MOVB_OPC_W]
                     == branch_decode_pkg::MOVB_OPC);
   assign is_movp = (w[branch_decode_pkg::MOVP_OPC_LSB +: MOVP_OPC_W]
                     == branch_decode_pkg::MOVP_OPC);
   assign pol_clear = w[branch_decode_pkg::BR_POL_BIT];
   assign sel = w[branch_decode_pkg::BR_SEL_LSB +: branch_decode_pkg::BR_SEL_W];

   // ****************************************
   // branch target
   // ****************************************
   assign offs = w[branch_decode_pkg::BR_OFFS_LSB +: branch_decode_pkg::OFFS_W];
   assign offs_ext = {{(PC_W - branch_decode_pkg::OFFS_W){offs[branch_decode_pkg::OFFS_W-1]}},
                      offs};
   // pc + k + 1, wrapped to pc width
   assign branch_target = pc + offs_ext + PC_W'(1);

   // ****************************************
   // copy addressing
   // ****************************************
   assign movb_dst = {w[branch_decode_pkg::MOVB_DHI_BIT], w[branch_decode_pkg::DST_LSB +: LOW_W]};
   assign movb_src = {w[branch_decode_pkg::MOVB_SHI_BIT], w[branch_decode_pkg::SRC_LSB +: LOW_W]};
   assign pair_dst = w[branch_decode_pkg::DST_LSB +: branch_decode_pkg::PAIR_W];
   assign pair_src = w[branch_decode_pkg::SRC_LSB +: branch_decode_pkg::PAIR_W];

   // ****************************************
   // condition select
   // ****************************************
   always_comb begin
      flag_val = 1'b0;
      supported_br = 1'b1;
      case (sel)
         branch_decode_pkg::SEL_C: begin
            flag_val = status.c;
            supported_br = !pol_clear;
         end
         branch_decode_pkg::SEL_N: begin
            flag_val = status.n;
         end
         branch_decode_pkg::SEL_V: begin
            flag_val = status.v;
            supported_br = !pol_clear;
         end
         branch_decode_pkg::SEL_S: begin
            flag_val = status.n ^ status.v;
         end
         branch_decode_pkg::SEL_H: begin
            flag_val = status.h;
         end
         branch_decode_pkg::SEL_T: begin
            flag_val = status.t;
         end
         default: begin
            supported_br = 1'b0;
         end
      endcase
      // set-polarity tests the flag high, clear-polarity tests it low
      cond = pol_clear ? !flag_val : flag_val;
   end

   assign taken = accept && is_branch && supported_br && cond;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      state_nxt = state_r;
      state_nxt.rd_data = state_r.regs[rd_addr];
      state_nxt.unsupported = 1'b0;
      if (reg_wr.en) begin
         state_nxt.regs[reg_wr.addr] = reg_wr.data;
      end
      unique case (state_r.phase)
         branch_decode_pkg::ST_IDLE: begin
            if (accept) begin
               if (is_branch) begin
                  state_nxt.unsupported = !supported_br;
                  if (taken) begin
                     state_nxt.target = branch_target;
                     state_nxt.phase = branch_decode_pkg::ST_TAKEN;
                  end
               end else if (is_movb) begin
                  state_nxt.regs[movb_dst] = state_r.regs[movb_src];
               end else if (is_movp) begin
                  // even register of each pair, then its odd partner
                  state_nxt.regs[{pair_dst, 1'b0}] = state_r.regs[{pair_src, 1'b0}];
                  state_nxt.regs[{pair_dst, 1'b1}] = state_r.regs[{pair_src, 1'b1}];
               end else begin
                  state_nxt.unsupported = 1'b1;
               end
            end
         end
         branch_decode_pkg::ST_TAKEN: begin
            state_nxt.phase = branch_decode_pkg::ST_IDLE;
         end
      endcase
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // no status write path exists, so every branch leaves flags as they were
   assign retire = (accept && !taken) || (state_r.phase == branch_decode_pkg::ST_TAKEN);
   assign pc_load = (state_r.phase == branch_decode_pkg::ST_TAKEN);
   assign pc_target = state_r.target;
   assign unsupported = state_r.unsupported;
   assign rd_data = state_r.rd_data;

endmodule // conditional_branch_decode

`default_nettype wire

// ### bench/conditional_branch_decode_asserts.sv
// checker for the branch and copy decoder
// assumes it sees only the decoder ports, bound below
`timescale 1ns/10ps
`default_nettype none
module conditional_branch_decode_asserts #(
   parameter int PC_W = 12
) (
   input wire logic clk,
   input wire logic rstn,
   input wire branch_decode_pkg::instr_t instr,
   input wire logic [PC_W-1:0] pc,
   input wire branch_decode_pkg::status_t status,
   input wire logic instr_ready,
   input wire logic retire,
   input wire logic pc_load,
   input wire logic [PC_W-1:0] pc_target,
   input wire logic unsupported
);
   logic [15:0] w;
   logic f, acc, sup, tk, nt, mv;
   logic [PC_W-1:0] tgt;
   always_comb begin
      w = instr.word;
      f = (w[2:0] == 3'h4) ? (status.n ^ status.v) : status[w[2:0]];
      acc = instr.valid && instr_ready;
      sup = !(w[2:0] == 3'h1 || w[2:0] == 3'h7 ||
              (w[10] && (w[2:0] == 3'h0 || w[2:0] == 3'h3)));
      tk = acc && sup && (w[15:11] == 5'h1e) && (f ^ w[10]);
      nt = acc && sup && (w[15:11] == 5'h1e) && !(f ^ w[10]);
      mv = acc && (w[15:10] == 6'h0b || w[15:8] == 8'h01);
      tgt = pc + {{(PC_W-7){w[9]}}, w[9:3]} + PC_W'(1);
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_take; tk; endsequence
   sequence s_load; pc_load && retire && !instr_ready; endsequence
   take_load_a: assert property (s_take |=> s_load)
      else $error("taken branch did not load");
   target_sum_a: assert property (tk |=> pc_target == $past(tgt))
      else $error("branch target wrong");
   untaken_stay_a: assert property (nt |-> retire && !pc_load ##1 !pc_load)
      else $error("untaken branch misbehaved");
   move_one_a: assert property (mv |-> retire && !pc_load ##1 !pc_load)
      else $error("copy not single cycle");
   load_cause_a: assert property (pc_load |-> $past(tk))
      else $error("load without taken branch");
   load_pulse_a: assert property (pc_load |=> !pc_load && instr_ready)
      else $error("load longer than one cycle");
   ready_low_a: assert property (!instr_ready |-> pc_load)
      else $error("stall outside taken branch");
   unk_flag_a: assert property (acc && !tk && !nt && !mv |=> unsupported)
      else $error("unknown word not flagged");
endmodule // conditional_branch_decode_asserts
bind conditional_branch_decode conditional_branch_decode_asserts #(.PC_W(PC_W)) u_chk (
   .clk(clk), .rstn(rstn), .instr(instr), .pc(pc), .status(status), .instr_ready(instr_ready),
   .retire(retire), .pc_load(pc_load), .pc_target(pc_target), .unsupported(unsupported));
`default_nettype wire

// ### bench/tb_conditional_branch_decode.sv
// self-checking bench for the branch and copy decoder
// assumes the checker is bound in by its own file
`timescale 1ns/10ps
`default_nettype none
module tb_conditional_branch_decode;
   logic clk, rstn, instr_ready, retire, pc_load, unsupported;
   logic [11:0] pc, pc_target;
   logic [4:0] rd_addr;
   logic [7:0] rd_data;
   branch_decode_pkg::instr_t instr;
   branch_decode_pkg::status_t status;
   branch_decode_pkg::reg_wr_t reg_wr;
   int miscompares, total_checks, cyc;
   localparam logic [3:0] CODES[10] = '{4'h0, 4'h2, 4'ha, 4'hc, 4'h4, 4'h5, 4'hd, 4'h6, 4'he, 4'h3};
   localparam logic [7:0] STATS[4] = '{8'h00, 8'hff, 8'h04, 8'h08};
   conditional_branch_decode #(.PC_W(12)) u_dut (.clk(clk), .rstn(rstn), .instr(instr),
      .pc(pc), .status(status), .reg_wr(reg_wr), .rd_addr(rd_addr), .instr_ready(instr_ready),
      .retire(retire), .pc_load(pc_load), .pc_target(pc_target), .unsupported(unsupported),
      .rd_data(rd_data));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         stop_test();
      end
   end
   task stop_test;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
      end
   endtask
   function logic tk_exp(input logic [3:0] c, input logic [7:0] s);
      return ((c[2:0] == 3'h4) ? s[2] ^ s[3] : s[c[2:0]]) ^ c[3];
   endfunction
   task br(input logic [3:0] c, input logic [6:0] k, input logic [7:0] s, input logic [11:0] a);
      logic t;
      logic [11:0] tg;
      t = tk_exp(c, s);
      tg = a + {{5{k[6]}}, k} + 12'h001;
      @(negedge clk);
      instr = {1'b1, 5'h1e, c[3], k, c[2:0]};
      pc = a;
      status = s;
      #5 chk("retire0", retire, !t);
      @(negedge clk);
      instr.valid = 1'b0;
      #1 chk("load", pc_load, t);
      chk("ready", instr_ready, !t);
      if (t) chk("target", pc_target, tg);
   endtask
   task t_branches;
      foreach (CODES[i]) foreach (STATS[j]) br(CODES[i], 7'(i * 13 + j * 37), STATS[j], 12'(i * 97));
      br(4'h0, 7'h7f, 8'h01, 12'h000);
      $display("test branches done");
   endtask
   task t_refused;
      br(4'h0, 7'h05, 8'h01, 12'h100);
      instr = {1'b1, 16'hf400};
      #2 chk("stall", instr_ready, 1'b0);
      @(negedge clk);
      #1 chk("unsup_early", unsupported, 1'b0);
      chk("retire_unk", retire, 1'b1);
      @(negedge clk);
      instr.valid = 1'b0;
      #1 chk("unsup", unsupported, 1'b1);
      chk("no_load", pc_load, 1'b0);
      $display("test refused done");
   endtask
   task t_reset;
      br(4'h0, 7'h02, 8'h01, 12'h010);
      rstn = 1'b0;
      #1 chk("rst_load", pc_load, 1'b0);
      chk("rst_ready", instr_ready, 1'b1);
      chk("rst_target", pc_target, 16'h0000);
      chk("rst_unsup", unsupported, 1'b0);
      chk("rst_rd", rd_data, 16'h0000);
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      br(4'h6, 7'h10, 8'h40, 12'h020);
      $display("test reset done");
   endtask
   task wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = {1'b1, a, d};
      @(negedge clk);
      reg_wr.en = 1'b0;
   endtask
   task mv(input logic [15:0] wd);
      @(negedge clk);
      instr = {1'b1, wd};
      #5 chk("mv_retire", retire, 1'b1);
      @(negedge clk);
      instr.valid = 1'b0;
      #1 chk("mv_load", pc_load, 1'b0);
   endtask
   task rd(input logic [4:0] a, input logic [7:0] e);
      @(negedge clk);
      rd_addr = a;
      @(negedge clk);
      #1 chk("rd", rd_data, e);
   endtask
   task t_moves;
      wr(5'h03, 8'h5a);
      wr(5'h04, 8'ha5);
      wr(5'h05, 8'h3c);
      mv(16'h2d43);
      rd(5'h14, 8'h5a);
      mv(16'h0152);
      rd(5'h0a, 8'ha5);
      rd(5'h0b, 8'h3c);
      $display("test moves done");
   endtask
   initial begin
      rstn = 1'b0;
      instr = '0;
      pc = '0;
      status = '0;
      reg_wr = '0;
      rd_addr = '0;
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      t_branches();
      t_refused();
      t_reset();
      t_moves();
      stop_test();
   end
endmodule // tb_conditional_branch_decode
`default_nettype wire
